// file: logic/gpms_defines.svh
// Timing constants and encodings for the power mode sequencer
`ifndef GPMS_DEFINES_SVH
`define GPMS_DEFINES_SVH
`define GPMS_CLK_HZ 10000000
`define GPMS_TOGGLE_MS 200
`define GPMS_TOGGLE_CYC ((`GPMS_CLK_HZ / 1000) * `GPMS_TOGGLE_MS)
`define GPMS_SHUT_MS 1000
`define GPMS_SHUT_CYC ((`GPMS_CLK_HZ / 1000) * `GPMS_SHUT_MS)
`define GPMS_STARTUP_MS 1000
`define GPMS_STARTUP_CYC ((`GPMS_CLK_HZ / 1000) * `GPMS_STARTUP_MS)
`define GPMS_SEC_CYC `GPMS_CLK_HZ
`define GPMS_PPS_OFS_NS 620
`define GPMS_PPS_OFS_CYC ((`GPMS_PPS_OFS_NS + 99) / 100)
`define GPMS_PPS_WIDTH_CYC 1000000
`define GPMS_TIME_MSG_MS 300
`define GPMS_TIME_MSG_CYC ((`GPMS_CLK_HZ / 1000) * `GPMS_TIME_MSG_MS)
`define GPMS_HIB_DLY_CYC 1000
`define GPMS_PTF_SEC 7200
`define GPMS_FAST_DIV 5
`define GPMS_CMD_FAST 4'h6
`define GPMS_CMD_SLOW 4'h7
`define GPMS_CMD_SHUT 4'h1
`endif

// file: logic/gpms_pkg.sv
// Types shared by both ends of the power mode link
package gpms_pkg;
    typedef enum logic [2:0] {
        GPMS_OFF, GPMS_FULL, GPMS_SHUTDOWN, GPMS_HIBERNATE, GPMS_PTF_SLEEP
    } gpms_mode_e;
    typedef enum logic [2:0] {
        GPMS_H_START, GPMS_H_IDLE, GPMS_H_PULSE, GPMS_H_WAIT, GPMS_H_CMD
    } gpms_host_e;
    typedef logic [3:0] gpms_cmd_t;
endpackage

// file: logic/gpms_if.sv
// Link between the receiver power sequencer and its host controller
`timescale 1ns/10ps
interface gpms_if;
    logic toggle;
    logic cmd_valid;
    logic [3:0] cmd_code;
    logic wake_indicator_out;
    logic second_pulse_out;
    logic time_msg;
    logic nav_tick;
    logic supply_on;
    modport device (input toggle, input cmd_valid, input cmd_code,
        input supply_on, output wake_indicator_out,
        output second_pulse_out, output time_msg, output nav_tick);
    modport host (output toggle, output cmd_valid, output cmd_code,
        output supply_on, input wake_indicator_out,
        input second_pulse_out, input time_msg, input nav_tick);
endinterface

// file: logic/gpms_device.sv
// Receiver end: power modes, second pulse, time message and nav rate
//
// Contract
// RQ1: Host starts shutdown by 200ms pulse or command
// RQ2: Shutdown finishes within 1s; supply held
// RQ3: Host never drops supply while running; host drops it on power_en_i low once idle and hold_r is zero
// RQ4: Toggle pulse requests fix, leaves low power
// RQ5: Push-to-fix sleeps up to 2 hours
// RQ6: Toggle pulse gives fix outside duty cycle
// RQ7: Shutdown pulse or command enters hibernate
// RQ8: Hibernate keeps clock and memory alive
// RQ9: 200ms toggle pulse wakes from hibernate
// RQ10: Second pulse pin is output only
// RQ11: Second pulse 620-710ns after each second
// RQ12: Time message about 300ms after pulse
// RQ13: Nav at 1Hz default, 5Hz on command
// RQ14: Rate command code 6 fast, 7 slow
// RQ15: Host first toggles after wake edge or 1s
// RQ16: Host waits out action before next toggle
// RQ17: Host times pulses from its own clock
`timescale 1ns/10ps
`include "gpms_defines.svh"
module gpms_device import gpms_pkg::*; #(
    parameter int unsigned SEC_CYC = `GPMS_SEC_CYC,
    parameter int unsigned TOGGLE_CYC = `GPMS_TOGGLE_CYC,
    parameter int unsigned SHUT_CYC = `GPMS_SHUT_CYC,
    parameter int unsigned TIME_MSG_CYC = `GPMS_TIME_MSG_CYC,
    parameter int unsigned PPS_WIDTH_CYC = `GPMS_PPS_WIDTH_CYC,
    parameter int unsigned PTF_SEC = `GPMS_PTF_SEC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    gpms_if.device link,
    input wire logic ptf_enable_i,
    output logic [2:0] mode_o,
    output logic fast_rate_o,
    output logic rtc_running_o
);
    // Toggle pin comes from another chip, so it is synchronised first
    logic tog_s1_r, tog_s2_r, tog_s3_r;
    logic [31:0] tog_len_r, tog_len_nxt;
    logic tog_evt;
    gpms_mode_e mode_r, mode_nxt;
    logic [31:0] mcnt_r, mcnt_nxt;
    logic [31:0] rtc_r, rtc_nxt;
    logic [31:0] sec_r, sec_nxt;
    logic [31:0] ptf_r, ptf_nxt;
    logic pps_r, pps_nxt;
    logic [31:0] ppsw_r, ppsw_nxt;
    logic [31:0] msg_r, msg_nxt;
    logic msg_pend_r, msg_pend_nxt;
    logic msg_r_o, msg_o_nxt;
    logic fast_r, fast_nxt;
    logic rtc_run_r, rtc_run_nxt;
    logic nav_r, nav_nxt;
    logic wake_r, wake_nxt;
    logic running;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end else begin
            tog_s1_r <= link.toggle;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    // A toggle counts on its falling edge once it was high long enough;
    // half the nominal width is accepted since "about 200ms" is loose
    always_comb begin
        tog_evt = 1'b0;
        tog_len_nxt = tog_len_r;
        if (tog_s2_r) begin
            if (tog_len_r != 32'hffffffff) begin
                tog_len_nxt = tog_len_r + 32'h1;
            end
        end else begin
            tog_len_nxt = 32'h0;
            if (tog_s3_r && tog_len_r >= (TOGGLE_CYC / 2)) begin
                tog_evt = 1'b1; // [RQ4] [RQ6] [RQ9]
            end
        end
    end

    assign running = (mode_r == GPMS_FULL);

    // Power mode state machine
    always_comb begin
        mode_nxt = mode_r;
        mcnt_nxt = mcnt_r;
        ptf_nxt = ptf_r;
        case (mode_r)
            GPMS_OFF: begin
                if (tog_evt) begin
                    mode_nxt = GPMS_FULL;
                end
            end
            GPMS_FULL: begin
                if (tog_evt || (link.cmd_valid &&
                        link.cmd_code == `GPMS_CMD_SHUT)) begin
                    mode_nxt = GPMS_SHUTDOWN; // [RQ1] [RQ7]
                    mcnt_nxt = 32'h0;
                end
            end
            GPMS_SHUTDOWN: begin
                // Half the limit, well inside the 1s bound
                if (mcnt_r >= (SHUT_CYC / 2) - 1) begin
                    mode_nxt = ptf_enable_i ? GPMS_PTF_SLEEP
                                            : GPMS_HIBERNATE; // [RQ2] [RQ7]
                    ptf_nxt = 32'h0;
                end else begin
                    mcnt_nxt = mcnt_r + 32'h1;
                end
            end
            GPMS_HIBERNATE: begin
                if (tog_evt) begin
                    mode_nxt = GPMS_FULL; // [RQ9]
                end
            end
            GPMS_PTF_SLEEP: begin
                if (tog_evt) begin
                    mode_nxt = GPMS_FULL; // [RQ6] [RQ4]
                end else if (sec_r == SEC_CYC - 1) begin
                    if (ptf_r >= PTF_SEC - 1) begin
                        mode_nxt = GPMS_FULL; // [RQ5]
                    end else begin
                        ptf_nxt = ptf_r + 32'h1;
                    end
                end
            end
            default: mode_nxt = GPMS_OFF;
        endcase
        // Supply loss forces the mode to off; the second counter and real-time clock keep counting
        if (!link.supply_on) begin
            mode_nxt = GPMS_OFF; // [RQ3]
        end
    end

    // Second counter and real-time clock keep running in hibernate
    always_comb begin
        sec_nxt = (sec_r == SEC_CYC - 1) ? 32'h0 : sec_r + 32'h1;
        rtc_nxt = (sec_r == SEC_CYC - 1) ? rtc_r + 32'h1 : rtc_r; // [RQ8]
        pps_nxt = pps_r;
        ppsw_nxt = ppsw_r;
        msg_nxt = msg_r;
        msg_pend_nxt = msg_pend_r;
        msg_o_nxt = 1'b0;
        if (running && sec_r == `GPMS_PPS_OFS_CYC - 1) begin
            pps_nxt = 1'b1; // [RQ11] [RQ10]
            ppsw_nxt = 32'h0;
            msg_pend_nxt = 1'b1;
            msg_nxt = 32'h0;
        end else if (pps_r) begin
            // A started pulse runs its full width; only power loss cuts it
            if (ppsw_r >= PPS_WIDTH_CYC - 1 || mode_r == GPMS_OFF) begin
                pps_nxt = 1'b0;
            end else begin
                ppsw_nxt = ppsw_r + 32'h1;
            end
        end
        if (msg_pend_r) begin
            if (!running) begin
                msg_pend_nxt = 1'b0;
            end else if (msg_r >= TIME_MSG_CYC - 1) begin
                msg_pend_nxt = 1'b0;
                msg_o_nxt = 1'b1; // [RQ12]
            end else begin
                msg_nxt = msg_r + 32'h1;
            end
        end
    end

    // Navigation rate and tick
    always_comb begin
        fast_nxt = fast_r;
        nav_nxt = 1'b0;
        if (link.cmd_valid && link.cmd_code == `GPMS_CMD_FAST) begin
            fast_nxt = 1'b1; // [RQ13]
        end else if (link.cmd_valid && link.cmd_code == `GPMS_CMD_SLOW) begin
            fast_nxt = 1'b0; // [RQ13]
        end
        if (mode_r == GPMS_OFF) begin
            fast_nxt = 1'b0;
        end
        if (sec_r % (SEC_CYC / `GPMS_FAST_DIV) == 0) begin
            nav_nxt = running && (fast_r || sec_r == 32'h0); // [RQ13]
        end
        wake_nxt = (mode_r != GPMS_OFF) && link.supply_on;
        // Reported running once the clock has ticked since the receiver left off with supply on
        rtc_run_nxt = wake_nxt && (rtc_run_r || rtc_nxt != rtc_r); // [RQ8]
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tog_len_r <= 32'h0;
            mode_r <= GPMS_OFF;
            mcnt_r <= 32'h0;
            rtc_r <= 32'h0;
            sec_r <= 32'h0;
            ptf_r <= 32'h0;
            pps_r <= 1'b0;
            ppsw_r <= 32'h0;
            msg_r <= 32'h0;
            msg_pend_r <= 1'b0;
            msg_r_o <= 1'b0;
            fast_r <= 1'b0;
            rtc_run_r <= 1'b0;
            nav_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            tog_len_r <= tog_len_nxt;
            mode_r <= mode_nxt;
            mcnt_r <= mcnt_nxt;
            rtc_r <= rtc_nxt;
            sec_r <= sec_nxt;
            ptf_r <= ptf_nxt;
            pps_r <= pps_nxt;
            ppsw_r <= ppsw_nxt;
            msg_r <= msg_nxt;
            msg_pend_r <= msg_pend_nxt;
            msg_r_o <= msg_o_nxt;
            fast_r <= fast_nxt;
            rtc_run_r <= rtc_run_nxt;
            nav_r <= nav_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign link.second_pulse_out = pps_r; // [RQ10]
    assign link.time_msg = msg_r_o;
    assign link.nav_tick = nav_r;
    assign link.wake_indicator_out = wake_r;
    assign mode_o = mode_r;
    assign fast_rate_o = fast_r;
    assign rtc_running_o = rtc_run_r;
endmodule

// file: logic/gpms_host.sv
// Host end: toggle pulse generator, supply hold and command sender
`timescale 1ns/10ps
`include "gpms_defines.svh"
module gpms_host import gpms_pkg::*; #(
    parameter int unsigned TOGGLE_CYC = `GPMS_TOGGLE_CYC,
    parameter int unsigned SHUT_CYC = `GPMS_SHUT_CYC,
    parameter int unsigned STARTUP_CYC = `GPMS_STARTUP_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    gpms_if.host link,
    input wire logic toggle_req_i,
    input wire logic cmd_req_i,
    input wire logic [3:0] cmd_code_i,
    input wire logic power_en_i,
    output logic busy_o,
    output logic started_o
);
    logic wk_s1_r, wk_s2_r, wk_s3_r;
    gpms_host_e st_r, st_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic tog_r, tog_nxt;
    logic cv_r, cv_nxt;
    logic [3:0] cc_r, cc_nxt;
    logic sup_r, sup_nxt;
    logic [31:0] hold_r, hold_nxt;
    logic started_r, started_nxt;
    logic busy_r, busy_nxt;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wk_s1_r <= 1'b0;
            wk_s2_r <= 1'b0;
            wk_s3_r <= 1'b0;
        end else begin
            wk_s1_r <= link.wake_indicator_out;
            wk_s2_r <= wk_s1_r;
            wk_s3_r <= wk_s2_r;
        end
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        tog_nxt = 1'b0; // [RQ17]
        cv_nxt = 1'b0;
        cc_nxt = cc_r;
        started_nxt = started_r;
        case (st_r)
            GPMS_H_START: begin
                // First toggle after wake rising edge or 1s
                if ((wk_s2_r && !wk_s3_r) || cnt_r >= STARTUP_CYC - 1) begin
                    st_nxt = GPMS_H_PULSE; // [RQ15]
                    cnt_nxt = 32'h0;
                    started_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            GPMS_H_IDLE: begin
                cnt_nxt = 32'h0;
                if (toggle_req_i) begin
                    st_nxt = GPMS_H_PULSE; // [RQ1] [RQ4] [RQ6] [RQ9]
                end else if (cmd_req_i) begin
                    st_nxt = GPMS_H_CMD; // [RQ14]
                    cc_nxt = cmd_code_i;
                end
            end
            GPMS_H_PULSE: begin
                tog_nxt = 1'b1; // [RQ17]
                // Stays high on the last count so the pulse is TOGGLE_CYC
                if (cnt_r >= TOGGLE_CYC - 1) begin
                    st_nxt = GPMS_H_WAIT;
                    cnt_nxt = 32'h0;
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            GPMS_H_WAIT: begin
                // No new toggle until shutdown could have ended
                if (cnt_r >= SHUT_CYC - 1) begin
                    st_nxt = GPMS_H_IDLE; // [RQ16]
                    cnt_nxt = 32'h0;
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            GPMS_H_CMD: begin
                cv_nxt = 1'b1; // [RQ14] [RQ7]
                st_nxt = GPMS_H_WAIT;
                cnt_nxt = 32'h0;
            end
            default: st_nxt = GPMS_H_IDLE;
        endcase
        if (st_r == GPMS_H_CMD || cv_r) begin
            cv_nxt = (st_r == GPMS_H_CMD);
        end
        busy_nxt = (st_nxt != GPMS_H_IDLE); // [RQ16]
    end

    // Supply stays on 1s after any possible shutdown start
    always_comb begin
        sup_nxt = sup_r;
        hold_nxt = hold_r;
        if (st_r == GPMS_H_PULSE || st_r == GPMS_H_CMD) begin
            hold_nxt = SHUT_CYC; // [RQ2]
        end else if (hold_r != 32'h0) begin
            hold_nxt = hold_r - 32'h1;
        end
        if (power_en_i) begin
            sup_nxt = 1'b1;
        end else if (hold_r == 32'h0 && st_r == GPMS_H_IDLE) begin
            sup_nxt = 1'b0; // [RQ3]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_r <= GPMS_H_START;
            cnt_r <= 32'h0;
            tog_r <= 1'b0;
            cv_r <= 1'b0;
            cc_r <= 4'h0;
            sup_r <= 1'b1;
            hold_r <= 32'h0;
            started_r <= 1'b0;
            busy_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            tog_r <= tog_nxt;
            cv_r <= cv_nxt;
            cc_r <= cc_nxt;
            sup_r <= sup_nxt;
            hold_r <= hold_nxt;
            started_r <= started_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign link.toggle = tog_r;
    assign link.cmd_valid = cv_r;
    assign link.cmd_code = cc_r;
    assign link.supply_on = sup_r;
    assign busy_o = busy_r;
    assign started_o = started_r;
endmodule

// file: dv/gpms_props.sv
// Concurrent checks on the link between host and receiver ends
`timescale 1ns/10ps
module gpms_props #(
    parameter int unsigned TOGGLE_CYC = 20,
    parameter int unsigned SHUT_CYC = 40,
    parameter int unsigned STARTUP_CYC = 30
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic toggle,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic wake_indicator_out,
    input wire logic second_pulse_out,
    input wire logic time_msg,
    input wire logic nav_tick,
    input wire logic supply_on
);
    logic [15:0] hi_r, hi_nxt, gap_r, gap_nxt, up_r, up_nxt;

    // Counters saturate so a long idle never wraps into a false gap
    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h1;
    endfunction

    always_comb begin
        hi_nxt = toggle ? inc(hi_r) : 16'h0;
        gap_nxt = (toggle | cmd_valid) ? 16'h0 : inc(gap_r);
        up_nxt = inc(up_r);
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            hi_r <= 16'h0;
            gap_r <= 16'hffff;
            up_r <= 16'h0;
        end else begin
            hi_r <= hi_nxt;
            gap_r <= gap_nxt;
            up_r <= up_nxt;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff reset_i;

    sequence pps_hold;
        second_pulse_out [*8] ##1 second_pulse_out [*2];
    endsequence

    toggle_width_a: assert property ($fell(toggle) |-> hi_r == TOGGLE_CYC)
        else $error("toggle pulse width wrong");
    toggle_gap_a: assert property ($rose(toggle) |-> gap_r >= SHUT_CYC)
        else $error("toggle pulses too close");
    first_toggle_a: assert property ($rose(toggle) |-> up_r >= STARTUP_CYC)
        else $error("first toggle too early");
    supply_hold_a: assert property (!supply_on |-> gap_r >= SHUT_CYC)
        else $error("supply dropped during shutdown");
    supply_off_a: assert property (!supply_on |-> ##[0:2] !wake_indicator_out)
        else $error("receiver awake without supply");
    cmd_single_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe too long");
    pps_width_a: assert property ($rose(second_pulse_out) |-> pps_hold ##1 !second_pulse_out)
        else $error("second pulse width wrong");
    pps_awake_a: assert property (second_pulse_out |-> wake_indicator_out)
        else $error("second pulse while off");
    time_msg_a: assert property (time_msg |-> $past(second_pulse_out, 30) || $past(second_pulse_out, 28))
        else $error("time message not after pulse");
endmodule

// file: dv/gnss_power_mode_sequencing_bench.sv
// Self-checking bench joining host and receiver ends
`timescale 1ns/10ps
module gnss_power_mode_sequencing_bench import gpms_pkg::*;;
    localparam int unsigned SEC = 100, TOG = 20, SHUT = 40, UP = 30;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic toggle_req = 1'b0, cmd_req = 1'b0, power_en = 1'b1, ptf_en = 1'b0;
    logic [3:0] cmd_code = 4'h0;
    logic busy, started, fast, rtc;
    logic [2:0] mode;
    logic [3:0] exp_q[$];
    logic [3:0] last_seen = 4'h0;
    logic [31:0] seed = 32'hd772;
    int fail_count = 0;
    int samples_checked = 0;
    int g;

    gpms_if link ();
    gpms_device #(.SEC_CYC(SEC), .TOGGLE_CYC(TOG), .SHUT_CYC(SHUT),
        .TIME_MSG_CYC(30), .PPS_WIDTH_CYC(10), .PTF_SEC(3)) u_gpms_device (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link),
        .ptf_enable_i(ptf_en), .mode_o(mode), .fast_rate_o(fast),
        .rtc_running_o(rtc));
    gpms_host #(.TOGGLE_CYC(TOG), .SHUT_CYC(SHUT), .STARTUP_CYC(UP))
        u_gpms_host (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link),
        .toggle_req_i(toggle_req), .cmd_req_i(cmd_req), .cmd_code_i(cmd_code),
        .power_en_i(power_en), .busy_o(busy), .started_o(started));
    gpms_props #(.TOGGLE_CYC(TOG), .SHUT_CYC(SHUT), .STARTUP_CYC(UP))
        u_gpms_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .toggle(link.toggle), .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .wake_indicator_out(link.wake_indicator_out),
        .second_pulse_out(link.second_pulse_out), .time_msg(link.time_msg),
        .nav_tick(link.nav_tick), .supply_on(link.supply_on));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Busy is read on the falling edge, clear of the register update
    task automatic wait_idle;
        int n = 0;
        repeat (3) @(negedge sys_clk_i);
        while (busy !== 1'b0 && n < 400) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (n >= 400) check("busy", 0, 1);
    endtask

    task automatic pulse(input logic tg, input logic [3:0] code);
        seed = xs(seed);
        repeat (seed[2:0]) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        toggle_req <= tg;
        cmd_req <= ~tg;
        cmd_code <= code;
        @(posedge sys_clk_i);
        toggle_req <= 1'b0;
        cmd_req <= 1'b0;
        wait_idle();
    endtask

    task automatic span(input logic nav, output int gap);
        logic prev = 1'b1;
        logic cur;
        int edges = 0;
        int n = 0;
        gap = 0;
        while (edges < 2 && n < 1000) begin
            @(negedge sys_clk_i);
            n++;
            cur = nav ? link.nav_tick : link.second_pulse_out;
            if (edges > 0) gap++;
            if (cur && !prev) edges++;
            prev = cur;
        end
    endtask

    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // Every change of rate or mode must match the oldest note
    initial begin
        @(negedge reset_i);
        forever begin
            @(negedge sys_clk_i);
            if ({fast, mode} !== last_seen) begin
                last_seen = {fast, mode};
                if (exp_q.size() == 0) check("mode", 4'hf, last_seen);
                else check("mode", exp_q.pop_front(), last_seen);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(negedge sys_clk_i);
        check("reset mode", {1'b0, GPMS_OFF}, {fast, mode});
        @(posedge sys_clk_i);
        toggle_req <= 1'b1;
        @(posedge sys_clk_i);
        toggle_req <= 1'b0;
        repeat (3) @(negedge sys_clk_i);
        check("early toggle", 0, link.toggle);
        for (int i = 0; i < 100 && started !== 1'b1; i++) @(negedge sys_clk_i);
        check("started", 1, started);
        // The start-up toggle itself wakes the receiver; host is busy
        exp_q.push_back({1'b0, GPMS_FULL});
        wait_idle();
        span(1'b0, g);
        check("second period", SEC, g);
        span(1'b1, g);
        check("nav slow", SEC, g);
        exp_q.push_back({1'b1, GPMS_FULL});
        pulse(1'b0, 4'h6);
        span(1'b1, g);
        check("nav fast", SEC / 5, g);
        repeat (3) begin
            seed = xs(seed);
            if (!(seed[3:0] inside {4'h1, 4'h6, 4'h7})) pulse(1'b0, seed[3:0]);
        end
        exp_q.push_back({1'b0, GPMS_FULL});
        pulse(1'b0, 4'h7);
        exp_q.push_back({1'b0, GPMS_SHUTDOWN});
        exp_q.push_back({1'b0, GPMS_HIBERNATE});
        pulse(1'b1, 4'h0);
        check("shutdown done", 0, exp_q.size());
        check("clock kept", 1, rtc);
        pulse(1'b0, 4'h1);
        exp_q.push_back({1'b0, GPMS_FULL});
        pulse(1'b1, 4'h0);
        @(posedge sys_clk_i);
        ptf_en <= 1'b1;
        exp_q.push_back({1'b0, GPMS_SHUTDOWN});
        exp_q.push_back({1'b0, GPMS_PTF_SLEEP});
        pulse(1'b0, 4'h1);
        // Timed wake comes on the third second rollover after entry
        exp_q.push_back({1'b0, GPMS_FULL});
        repeat (150) @(negedge sys_clk_i);
        check("still asleep", 1, exp_q.size());
        repeat (200) @(negedge sys_clk_i);
        check("timed wake", 0, exp_q.size());
        exp_q.push_back({1'b0, GPMS_SHUTDOWN});
        exp_q.push_back({1'b0, GPMS_PTF_SLEEP});
        pulse(1'b0, 4'h1);
        exp_q.push_back({1'b0, GPMS_FULL});
        pulse(1'b1, 4'h0);
        @(posedge sys_clk_i);
        ptf_en <= 1'b0;
        exp_q.push_back({1'b1, GPMS_FULL});
        pulse(1'b0, 4'h6);
        exp_q.push_back({1'b1, GPMS_SHUTDOWN});
        exp_q.push_back({1'b1, GPMS_HIBERNATE});
        pulse(1'b1, 4'h0);
        // Power is dropped only once the receiver has stopped running
        @(posedge sys_clk_i);
        power_en <= 1'b0;
        // Rate flag clears one cycle after the mode drops to off
        exp_q.push_back({1'b1, GPMS_OFF});
        exp_q.push_back({1'b0, GPMS_OFF});
        repeat (8) @(negedge sys_clk_i);
        check("power off", 0, exp_q.size());
        check("supply", 0, link.supply_on);
        summarize();
    end
endmodule
